// ==== src/occ_regs.svh ====
// register offsets, field positions, reset values for the output compare channel
// assumes a 32-bit axi4-lite register window, byte addressed
`ifndef OCC_REGS_SVH
`define OCC_REGS_SVH
`define OCC_CTRL_OFS 8'h00
`define OCC_PRI_OFS 8'h04
`define OCC_SEC_OFS 8'h08
`define OCC_STAT_OFS 8'h0c
`define OCC_MASK_OFS 8'h10
`define OCC_ON_BIT 15
`define OCC_STOP_IN_IDLE_BIT 13
`define OCC_WIDE_BIT 5
`define OCC_FLT_BIT 4
`define OCC_TSEL_BIT 3
`define OCC_CTRL_WMASK 32'h0000_a02f
`define OCC_CTRL_RST 32'h0000_0000
`define OCC_EV_CMP 0
`define OCC_EV_END 1
`define OCC_EV_FLT 2
`define OCC_EV_W 3
`endif

// ==== src/occ_pkg.sv ====
// types shared by the output compare channel
// assumes nothing beyond the header of constants
package occ_pkg;
  typedef enum logic [2:0] {
    OCC_OFF = 3'h0, OCC_SET_HI = 3'h1, OCC_SET_LO = 3'h2, OCC_TOGGLE = 3'h3,
    OCC_ONE_PULSE = 3'h4, OCC_PULSES = 3'h5, OCC_PWM = 3'h6, OCC_PWM_FLT = 3'h7
  } occ_mode_t;
  typedef enum logic [2:0] {
    OCC_ST_IDLE = 3'b001, OCC_ST_WAIT = 3'b010, OCC_ST_DONE = 3'b100
  } occ_state_t;
endpackage : occ_pkg

// ==== src/occ_axil.sv ====
// axi4-lite slave front end: one write and one read in flight
// assumes a master that holds valid and payload until taken
module occ_axil (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // axi4-lite
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_held;
  logic w_held;

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_en = aw_held && w_held && !bvalid;
  assign rd_addr = araddr;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_ok ? rd_data : 32'h0000_0000;
      rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : occ_axil

// ==== src/occ_sync.sv ====
// two-flop synchroniser for a level from a pin
// assumes the input may change at any time
module occ_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // level
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : occ_sync

// ==== src/occ_top.sv ====
// output compare channel: control register, compare logic, output pin drive
// assumes timers and idle state come from logic on ref_clk; fault from a pin
//
// Behaviour
// - channel works only while enable bit 15 is one
// - with stop_in_idle set, channel halts while device is idle
// - wide_compare_select picks 32-bit compare, else low 16 bits only
// - fault flag set by hardware, cleared by hardware only, software cannot write
// - fault flag meaningful only in mode 111, reads zero otherwise
// - timer_source_select one picks second timer, zero picks first timer
// - mode 111 pwm with fault input, mode 110 pwm ignoring fault
// - mode 101 drives pin low, then continuous pulses
// - mode 100 drives pin low, then exactly one pulse
// - mode 011 toggles pin on every compare event
// - mode 010 starts pin high, compare event forces low
// - mode 001 starts pin low, compare event forces high
// - mode 000 leaves compare disabled, logic still powered
// - unimplemented control bits 31-16, 14, 12-6 read as zero
`include "occ_regs.svh"
module occ_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // axi4-lite
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // timers and device state
  input wire logic [31:0] first_timer_source,
  input wire logic [31:0] second_timer_source,
  input wire logic device_idle,
  // pins
  input wire logic fault_pin_n,
  output logic compare_output_pin,
  output logic compare_output_oe,
  // interrupt
  output logic irq
);
  import occ_pkg::*;

  logic [31:0] output_compare_control;
  logic [31:0] primary_compare_value;
  logic [31:0] secondary_compare_value;
  logic [`OCC_EV_W-1:0] event_status;
  logic [`OCC_EV_W-1:0] event_mask;
  logic pwm_fault_flag;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic fault_sync_n;
  occ_mode_t compare_mode_select;
  occ_mode_t last_mode;
  occ_state_t state;
  logic run;
  logic [31:0] timer_now;
  logic [31:0] timer_prev;
  logic timer_moved;
  logic hit_pri;
  logic hit_sec;
  logic ev_cmp;
  logic ev_end;
  logic ev_flt;
  logic mode_change;

  // merge byte lanes of a write into an old word
  function automatic logic [31:0] occ_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : occ_merge

  // compare at the selected width
  function automatic logic occ_match(input logic [31:0] a, input logic [31:0] b,
                                     input logic wide);
    return wide ? (a == b) : (a[15:0] == b[15:0]);
  endfunction : occ_match

  occ_axil u_axil (
    .ref_clk(ref_clk),
    .rst(rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // fault pin is asynchronous; the synchroniser resets to the active level,
  // harmless because the control word stays clear for far longer than two edges
  occ_sync #(.WIDTH(1)) u_fault_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(fault_pin_n),
    .q(fault_sync_n)
  );

  assign compare_mode_select = occ_mode_t'(output_compare_control[2:0]);

  // enable gate, with optional halt while the device idles
  assign run = output_compare_control[`OCC_ON_BIT] &&
               !(output_compare_control[`OCC_STOP_IN_IDLE_BIT] && device_idle);

  // timer choice, narrowed when not wide
  always_comb begin
    timer_now = output_compare_control[`OCC_TSEL_BIT] ? second_timer_source
                                                      : first_timer_source;
    if (!output_compare_control[`OCC_WIDE_BIT]) begin
      timer_now = {16'h0000, timer_now[15:0]};
    end
  end

  // a match counts once per timer value, so a stopped timer gives no repeat events
  assign timer_moved = (timer_now != timer_prev);
  assign hit_pri = run && timer_moved &&
                   occ_match(timer_now, primary_compare_value,
                             output_compare_control[`OCC_WIDE_BIT]);
  assign hit_sec = run && timer_moved &&
                   occ_match(timer_now, secondary_compare_value,
                             output_compare_control[`OCC_WIDE_BIT]);

  // starts away from any real count so the first timer value counts as a move
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_prev <= 32'hffff_ffff;
    end else begin
      timer_prev <= timer_now;
    end
  end

  // register decode
  always_comb begin
    unique case (wr_addr)
      `OCC_CTRL_OFS, `OCC_PRI_OFS, `OCC_SEC_OFS, `OCC_STAT_OFS, `OCC_MASK_OFS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // read side: fault bit shown only in mode 111, unimplemented bits read zero
  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      `OCC_CTRL_OFS: begin
        rd_data = output_compare_control;
        rd_data[`OCC_FLT_BIT] = pwm_fault_flag && (compare_mode_select == OCC_PWM_FLT);
      end
      `OCC_PRI_OFS: rd_data = primary_compare_value;
      `OCC_SEC_OFS: rd_data = secondary_compare_value;
      `OCC_STAT_OFS: rd_data = {29'h0000_0000, event_status};
      `OCC_MASK_OFS: rd_data = {29'h0000_0000, event_mask};
      default: rd_ok = 1'b0;
    endcase
  end

  // control register: only implemented bits hold, fault bit not writable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      output_compare_control <= `OCC_CTRL_RST;
    end else if (wr_en && wr_addr == `OCC_CTRL_OFS) begin
      output_compare_control <= occ_merge(output_compare_control, wr_data, wr_strb) &
                                `OCC_CTRL_WMASK;
    end
  end

  // both words kept whole; the narrow mode only looks at the low half
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      primary_compare_value <= 32'h0000_0000;
      secondary_compare_value <= 32'h0000_0000;
    end else if (wr_en) begin
      if (wr_addr == `OCC_PRI_OFS) begin
        primary_compare_value <= occ_merge(primary_compare_value, wr_data, wr_strb);
      end
      if (wr_addr == `OCC_SEC_OFS) begin
        secondary_compare_value <= occ_merge(secondary_compare_value, wr_data, wr_strb);
      end
    end
  end

  // fault flag: set on fault in mode 111, cleared by hardware when the fault
  // input has gone and a new period starts, or when the mode is left
  assign ev_flt = run && (compare_mode_select == OCC_PWM_FLT) && !fault_sync_n && !pwm_fault_flag;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwm_fault_flag <= 1'b0;
    end else if (run && (compare_mode_select == OCC_PWM_FLT) && !fault_sync_n) begin
      pwm_fault_flag <= 1'b1;
    end else if (compare_mode_select != OCC_PWM_FLT || (hit_pri && fault_sync_n)) begin
      pwm_fault_flag <= 1'b0;
    end
  end

  // a mode write or a dropped enable restarts the pin from its initial level
  assign mode_change = (compare_mode_select != last_mode) || !output_compare_control[`OCC_ON_BIT];

  // mode seen on the last edge, forced off while disabled
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_mode <= OCC_OFF;
    end else begin
      last_mode <= output_compare_control[`OCC_ON_BIT] ? compare_mode_select : OCC_OFF;
    end
  end

  // pulse sequencing for single and continuous pulse modes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= OCC_ST_IDLE;
    end else if (mode_change) begin
      state <= OCC_ST_IDLE;
    end else begin
      unique case (state)
        OCC_ST_IDLE: begin
          if (hit_pri && (compare_mode_select == OCC_ONE_PULSE ||
                          compare_mode_select == OCC_PULSES)) begin
            state <= OCC_ST_WAIT;
          end
        end
        OCC_ST_WAIT: begin
          if (hit_sec) begin
            state <= (compare_mode_select == OCC_PULSES) ? OCC_ST_IDLE
                                                         : OCC_ST_DONE;
          end
        end
        OCC_ST_DONE: state <= OCC_ST_DONE;
        default: state <= OCC_ST_IDLE;
      endcase
    end
  end

  // output pin drive per mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      compare_output_pin <= 1'b0;
    end else if (mode_change) begin
      compare_output_pin <= output_compare_control[`OCC_ON_BIT] &&
                            (compare_mode_select == OCC_SET_LO);
    end else if (run) begin
      unique case (compare_mode_select)
        OCC_OFF: compare_output_pin <= 1'b0;
        OCC_SET_HI: begin
          if (hit_pri) compare_output_pin <= 1'b1;
        end
        OCC_SET_LO: begin
          if (hit_pri) compare_output_pin <= 1'b0;
        end
        OCC_TOGGLE: begin
          if (hit_pri) compare_output_pin <= !compare_output_pin;
        end
        OCC_ONE_PULSE, OCC_PULSES: begin
          if (state == OCC_ST_IDLE && hit_pri) compare_output_pin <= 1'b1;
          else if (state == OCC_ST_WAIT && hit_sec) compare_output_pin <= 1'b0;
        end
        OCC_PWM, OCC_PWM_FLT: begin
          // primary starts the high phase, secondary ends it; in mode 111 fault holds low
          if (compare_mode_select == OCC_PWM_FLT &&
              (pwm_fault_flag || !fault_sync_n)) compare_output_pin <= 1'b0;
          else if (hit_pri) compare_output_pin <= 1'b1;
          else if (hit_sec) compare_output_pin <= 1'b0;
        end
      endcase
    end
  end

  // pin released whenever the channel cannot drive it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      compare_output_oe <= 1'b0;
    end else begin
      compare_output_oe <= output_compare_control[`OCC_ON_BIT] &&
                           (compare_mode_select != OCC_OFF);
    end
  end

  // events: set beats a write-one clear in the same cycle
  assign ev_cmp = hit_pri && (compare_mode_select != OCC_OFF);
  assign ev_end = hit_sec && (state == OCC_ST_WAIT);

  // status and mask use byte lane 0 only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      event_status <= '0;
      event_mask <= '0;
    end else begin
      if (wr_en && wr_addr == `OCC_MASK_OFS && wr_strb[0]) begin
        event_mask <= wr_data[`OCC_EV_W-1:0];
      end
      event_status <= (event_status &
                       ~((wr_en && wr_addr == `OCC_STAT_OFS && wr_strb[0]) ?
                         wr_data[`OCC_EV_W-1:0] : {`OCC_EV_W{1'b0}})) |
                      {ev_flt, ev_end, ev_cmp};
    end
  end

  // level output, stays high until every unmasked event is cleared or masked
  assign irq = |(event_status & event_mask);
endmodule : occ_top

// ==== dv/occ_top_assertions.sv ====
// checker on the ports of the output compare channel top
// assumes one clock, active-high async reset, full-word writes
`include "occ_regs.svh"
module occ_top_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // device and pins
  input wire logic device_idle,
  input wire logic fault_pin_n,
  input wire logic compare_output_pin,
  input wire logic compare_output_oe,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wa, ra;
  logic [31:0] wd, c_q;
  logic bv_q;
  // shadow of the control word, committed with the write response
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wa <= '0;
      ra <= '0;
      wd <= '0;
      c_q <= '0;
      bv_q <= 1'b0;
    end else begin
      bv_q <= bvalid;
      if (awvalid && awready) wa <= awaddr;
      if (wvalid && wready) wd <= wdata;
      if (arvalid && arready) ra <= araddr;
      if (bvalid && !bv_q && wa == `OCC_CTRL_OFS && bresp == 2'h0) c_q <= wd & `OCC_CTRL_WMASK;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed early");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  AST_AW_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  AST_R_LAT: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  AST_OE: assert property (c_q == $past(c_q, 2) |->
    compare_output_oe == (c_q[15] && c_q[2:0] != 3'h0)) else $error("output enable wrong");
  AST_RSVD: assert property (rvalid && ra == 8'h00 && rresp == 2'h0 |->
    (rdata & ~32'h0000_a03f) == 32'h0) else $error("unimplemented control bit set");
  AST_FLAG: assert property (rvalid && ra == 8'h00 && rdata[2:0] != 3'h7 |->
    !rdata[4]) else $error("fault flag outside pwm fault mode");
  AST_FAULT: assert property ((!fault_pin_n && !device_idle && c_q[15]
    && c_q[2:0] == 3'h7) [*5] |-> !compare_output_pin) else $error("fault not forcing low");
  AST_IDLE: assert property (c_q == $past(c_q, 2) && c_q[13] && $past(device_idle)
    |-> $stable(compare_output_pin)) else $error("pin moved while halted");
  cover property (irq);
  cover property (!fault_pin_n && c_q[2:0] == 3'h7 && !compare_output_pin);
  cover property (rvalid && rresp == 2'h2);
endmodule : occ_top_assertions

bind occ_top occ_top_assertions u_chk (.ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata,
  .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
  .rvalid, .rready, .device_idle, .fault_pin_n, .compare_output_pin, .compare_output_oe, .irq);

// ==== dv/occ_pin_model.sv ====
// circuitry beside the compare output and fault pins
// assumes the bench raises fault_req just after a rising edge
module occ_pin_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request from bench
  input wire logic fault_req,
  // pins
  input wire logic compare_output_pin,
  input wire logic compare_output_oe,
  output logic fault_pin_n,
  output logic [7:0] pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pin_q;
  // pulled up, so a released line reads inactive
  assign fault_pin_n = !fault_req;
  // rising edges seen only while the pin is driven
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_q <= 1'b0;
      pulses <= '0;
    end else begin
      pin_q <= compare_output_pin;
      if (compare_output_oe && compare_output_pin && !pin_q) pulses <= pulses + 8'h01;
    end
  end
endmodule : occ_pin_model

// ==== dv/tb_top.sv ====
// self-checking bench for the output compare channel
// assumes occ_top with its bound checker and the pin model
`include "occ_regs.svh"
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] r;} occ_row_t;
  logic ref_clk, rst, awvalid, wvalid, bready, arvalid, rready, device_idle, fault_req;
  logic awready, wready, bvalid, arready, rvalid, fault_pin_n, irq;
  logic compare_output_pin, compare_output_oe;
  logic [7:0] awaddr, araddr, pulses, pc;
  logic [31:0] wdata, rdata, rv, first_timer_source, second_timer_source;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr;
  int bad_count, n_checks;
  occ_row_t rows [7] = '{'{8'h00, 32'hffff_ffff, 32'h0000_a02f, 2'h0},
    '{8'h00, 32'h0000_0010, 32'h0, 2'h0}, '{8'h04, 32'hffff_ffff, 32'hffff_ffff, 2'h0},
    '{8'h08, 32'h1234_5678, 32'h1234_5678, 2'h0}, '{8'h10, 32'hffff_ffff, 32'h7, 2'h0},
    '{8'h0c, 32'hffff_ffff, 32'h0, 2'h0}, '{8'h14, 32'h5, 32'h0, 2'h2}};
  occ_top dut (.ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .first_timer_source, .second_timer_source, .device_idle, .fault_pin_n,
    .compare_output_pin, .compare_output_oe, .irq);
  occ_pin_model u_pins (.ref_clk, .rst, .fault_req, .compare_output_pin, .compare_output_oe,
    .fault_pin_n, .pulses);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // one write or one read; handshakes judged at the negedge before the taking edge
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    bit ta, tw, tr, tb;
    n = 0;
    tb = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    bready <= w;
    rready <= !w;
    while (!tb && n < 40) begin
      @(negedge ref_clk);
      n++;
      ta = awready;
      tw = wready;
      tr = arready;
      tb = w ? bvalid : rvalid;
      rv = rdata;
      rr = w ? bresp : rresp;
      @(posedge ref_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    @(negedge ref_clk);
    if (!tb) begin
      bad_count++;
      report_and_stop();
    end
  endtask : xfer
  task automatic zero;
    @(posedge ref_clk);
    first_timer_source <= '0;
    second_timer_source <= '0;
    repeat (2) @(negedge ref_clk);
  endtask : zero
  task automatic step(input bit s, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      if (s) second_timer_source <= second_timer_source + 32'h1;
      else first_timer_source <= first_timer_source + 32'h1;
    end
    repeat (3) @(negedge ref_clk);
  endtask : step
  // enable cleared first so every mode starts from its initial pin level
  task automatic setup(input logic [31:0] c, input logic [31:0] p, input logic [31:0] s);
    xfer(1, `OCC_PRI_OFS, p);
    xfer(1, `OCC_SEC_OFS, s);
    xfer(1, `OCC_CTRL_OFS, 32'h0);
    zero;
    xfer(1, `OCC_CTRL_OFS, c);
  endtask : setup
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, device_idle, fault_req} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    first_timer_source = '0;
    second_timer_source = '0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    xfer(0, `OCC_CTRL_OFS, 32'h0);
    `CHK(rv, 32'h0)
    foreach (rows[i]) begin
      xfer(1, rows[i].a, rows[i].w);
      `CHK(rr, rows[i].r)
      xfer(0, rows[i].a, 32'h0);
      `CHK({rr, rv}, {rows[i].r, rows[i].e})
    end
    setup(32'h0000_8001, 32'h5, 32'h9);
    `CHK({compare_output_oe, compare_output_pin}, 2'b10)
    step(0, 5);
    `CHK(compare_output_pin, 1'b1)
    setup(32'h0000_8002, 32'h5, 32'h9);
    `CHK(compare_output_pin, 1'b1)
    step(0, 5);
    `CHK(compare_output_pin, 1'b0)
    setup(32'h0000_8003, 32'h5, 32'h9);
    step(0, 5);
    `CHK(compare_output_pin, 1'b1)
    zero;
    step(0, 5);
    `CHK(compare_output_pin, 1'b0)
    setup(32'h0000_800b, 32'h5, 32'h9);
    step(0, 5);
    `CHK(compare_output_pin, 1'b0)
    step(1, 5);
    `CHK(compare_output_pin, 1'b1)
    setup(32'h0000_8001, 32'h0001_0005, 32'h9);
    step(0, 5);
    `CHK(compare_output_pin, 1'b1)
    setup(32'h0000_8021, 32'h0001_0005, 32'h9);
    step(0, 5);
    `CHK(compare_output_pin, 1'b0)
    setup(32'h0000_0001, 32'h5, 32'h9);
    step(0, 5);
    `CHK({compare_output_oe, compare_output_pin}, 2'b00)
    setup(32'h0000_8000, 32'h5, 32'h9);
    step(0, 5);
    `CHK({compare_output_oe, compare_output_pin}, 2'b00)
    @(posedge ref_clk);
    device_idle <= 1'b1;
    setup(32'h0000_a001, 32'h5, 32'h9);
    step(0, 5);
    `CHK(compare_output_pin, 1'b0)
    @(posedge ref_clk);
    device_idle <= 1'b0;
    zero;
    step(0, 5);
    `CHK(compare_output_pin, 1'b1)
    xfer(1, `OCC_MASK_OFS, 32'h0);
    setup(32'h0000_8001, 32'h5, 32'h9);
    xfer(1, `OCC_STAT_OFS, 32'h7);
    step(0, 5);
    `CHK(irq, 1'b0)
    xfer(0, `OCC_STAT_OFS, 32'h0);
    `CHK(rv[0], 1'b1)
    xfer(1, `OCC_MASK_OFS, 32'h1);
    `CHK(irq, 1'b1)
    xfer(1, `OCC_STAT_OFS, 32'h1);
    `CHK(irq, 1'b0)
    setup(32'h0000_8006, 32'h3, 32'h8);
    @(posedge ref_clk);
    fault_req <= 1'b1;
    step(0, 4);
    `CHK(compare_output_pin, 1'b1)
    step(0, 5);
    `CHK(compare_output_pin, 1'b0)
    xfer(0, `OCC_CTRL_OFS, 32'h0);
    `CHK(rv[4], 1'b0)
    setup(32'h0000_8007, 32'h3, 32'h8);
    step(0, 4);
    `CHK(compare_output_pin, 1'b0)
    xfer(1, `OCC_CTRL_OFS, 32'h0000_8007);
    xfer(0, `OCC_CTRL_OFS, 32'h0);
    `CHK(rv[4], 1'b1)
    xfer(0, `OCC_STAT_OFS, 32'h0);
    `CHK(rv[2], 1'b1)
    @(posedge ref_clk);
    fault_req <= 1'b0;
    zero;
    step(0, 4);
    xfer(0, `OCC_CTRL_OFS, 32'h0);
    `CHK(rv[4], 1'b0)
    for (int m = 4; m < 6; m++) begin
      setup(32'h0000_8000 | 32'(m), 32'h3, 32'h6);
      `CHK(compare_output_pin, 1'b0)
      pc = pulses;
      step(0, 8);
      zero;
      step(0, 8);
      `CHK(8'(pulses - pc), 8'(m - 3))
    end
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    xfer(0, `OCC_CTRL_OFS, 32'h0);
    `CHK({compare_output_oe, rv}, 33'h0)
    report_and_stop();
  end
endmodule : tb_top
